// file: verilog/ptc_timer.sv
// Timer pair: 8-bit counter zero and 16-bit counter one behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "ptc_regs.svh"
// How it works
// - Counter one runs PWM at 8, 9 or 10 bits, top 0x00ff at 8 bits, never above resolution.
// - In PWM the counter one bits above the resolution are forced to zero every cycle.
// - In PWM the compare values of counter one lose the bits above the chosen resolution.
// - Clear on compare happens after the last prescaled tick that holds the compare value.
// - Software can reset the shared prescaler to restart its count sequence.
// - A variable top register sets the PWM range of counter one.
// - Counter one has a phase and frequency correct PWM mode beside phase correct PWM.
// - Counter zero counts, clears on compare and makes phase correct PWM with compare outputs.
// - Each counter has compare channels A and B; both set a flag and drive a pin, only A clears the counter.
// - Compare flag and pin update after the last prescaled tick that holds the compare value.
// - In PWM a compare write goes to a buffer copied to the active value at top.
// - Compare pins reset to zero and hold their level while disabled, resuming from it.
module ptc_timer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [3:0]       compare_output_pin,
	output logic [3:0]       compare_output_pin_oe
);
	logic                  wr_en;
	logic [31:0]           waddr;
	logic                  wr_ok;
	logic [2:0]            sel0;
	logic [2:0]            sel1;
	logic [9:0]            presc;
	logic                  tick0;
	logic                  tick1;
	ptc_pkg::ptc_t0cfg_type cfg0;
	ptc_pkg::ptc_t1cfg_type cfg1;
	logic [7:0]            counter_value;
	logic                  up0;
	logic [7:0]            cmpa0;
	logic [7:0]            cmpb0;
	logic [7:0]            bufa0;
	logic [7:0]            bufb0;
	logic [15:0]           counter1_value;
	logic                  up1;
	logic [15:0]           counter1_compare_value;
	logic [15:0]           cmpb1;
	logic [15:0]           bufa1;
	logic [15:0]           bufb1;
	logic [15:0]           top_buf1;
	logic [15:0]           top_act1;
	logic [5:0]            flags;
	logic [3:0]            pin;
	logic [7:0]            next_cnt0;
	logic                  next_up0;
	logic [15:0]           next_cnt1;
	logic                  next_up1;
	logic                  pwm0;
	logic                  pwm1;
	logic [15:0]           mask1;
	logic [15:0]           top1;
	logic                  at_top0;
	logic                  at_top1;
	logic                  at_bot1;
	logic [3:0]            hit;
	logic                  ovf0;
	logic                  ovf1;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;

	function automatic logic psc_tick(input logic [2:0] sel, input logic [9:0] p);
		case (sel)
			3'h1: psc_tick = 1'b1;
			3'h2: psc_tick = ((p & `PTC_TAP8) == `PTC_TAP8);
			3'h3: psc_tick = ((p & `PTC_TAP64) == `PTC_TAP64);
			3'h4: psc_tick = ((p & `PTC_TAP256) == `PTC_TAP256);
			3'h5: psc_tick = (p == `PTC_TAP1024);
			default: psc_tick = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
			input logic [1:0] strb);
		merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	// Upcounting match clears, downcounting match sets, plain modes toggle
	function automatic logic pin_next(input logic pwm, input logic up, input logic cur);
		pin_next = pwm ? ~up : ~cur;
	endfunction

	// Write address and data are taken together, so either arrival order works
	assign s_axi_awready = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign wr_en = s_axi_awready;
	assign waddr = s_axi_awaddr;
	assign wr_ok = (waddr == `PTC_CTRL_OFF) || (waddr == `PTC_T0CFG_OFF) ||
		(waddr == `PTC_T0CNT_OFF) || (waddr == `PTC_T0CMP_OFF) || (waddr == `PTC_T1CFG_OFF) ||
		(waddr == `PTC_T1CNT_OFF) || (waddr == `PTC_T1CMPA_OFF) || (waddr == `PTC_T1CMPB_OFF) ||
		(waddr == `PTC_T1TOP_OFF) || (waddr == `PTC_FLAGS_OFF);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PTC_RESP_OKAY;
		end else if (ce) begin
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= 10'h000;
			sel0  <= 3'h0;
			sel1  <= 3'h0;
		end else if (ce) begin
			if (wr_en && waddr == `PTC_CTRL_OFF && s_axi_wstrb[1] &&
					s_axi_wdata[`PTC_CTRL_PSCRST_BIT]) begin
				presc <= 10'h000;
			end else begin
				presc <= presc + 10'h001;
			end
			if (wr_en && waddr == `PTC_CTRL_OFF && s_axi_wstrb[0]) begin
				sel0 <= s_axi_wdata[`PTC_CTRL_SEL0_LSB +: 3];
				sel1 <= s_axi_wdata[`PTC_CTRL_SEL1_LSB +: 3];
			end
		end
	end
	assign tick0 = psc_tick(sel0, presc);
	assign tick1 = psc_tick(sel1, presc);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg0 <= '0;
			cfg1 <= '0;
		end else if (ce && wr_en && s_axi_wstrb[0]) begin
			if (waddr == `PTC_T0CFG_OFF) begin
				cfg0 <= ptc_pkg::ptc_t0cfg_type'(s_axi_wdata[3:0]);
			end else if (waddr == `PTC_T1CFG_OFF) begin
				cfg1 <= ptc_pkg::ptc_t1cfg_type'(s_axi_wdata[4:0]);
			end
		end
	end

	assign pwm0 = cfg0.mode[1];
	assign pwm1 = (cfg1.mode != ptc_pkg::PTC_T1_NORMAL) && (cfg1.mode != ptc_pkg::PTC_T1_CTC);
	always_comb begin
		case (cfg1.mode)
			ptc_pkg::PTC_T1_PWM8:  mask1 = `PTC_TOP8_VAL;
			ptc_pkg::PTC_T1_PWM9:  mask1 = `PTC_TOP9_VAL;
			ptc_pkg::PTC_T1_PWM10: mask1 = `PTC_TOP10_VAL;
			default:               mask1 = `PTC_FULL_MASK;
		endcase
	end
	assign top1 = (mask1 != `PTC_FULL_MASK) ? mask1 : top_act1;

	// Channel matches on the tick that leaves the value
	assign hit[0] = tick0 && (counter_value == cmpa0);
	assign hit[1] = tick0 && (counter_value == cmpb0);
	assign hit[2] = tick1 && (counter1_value == counter1_compare_value);
	assign hit[3] = tick1 && (counter1_value == cmpb1);
	assign at_top0 = tick0 && pwm0 && up0 && (counter_value == 8'hff);
	assign at_top1 = tick1 && pwm1 && up1 && (counter1_value >= top1);
	assign at_bot1 = tick1 && pwm1 && !up1 && (counter1_value == 16'h0000);
	assign ovf0 = tick0 && (pwm0 ? (!up0 && counter_value == 8'h00) : (counter_value == 8'hff));
	assign ovf1 = (cfg1.mode == ptc_pkg::PTC_T1_NORMAL) ? (tick1 && counter1_value == 16'hffff)
		: (pwm1 ? at_bot1 : 1'b0);

	always_comb begin
		next_cnt0 = counter_value;
		next_up0  = up0;
		if (wr_en && waddr == `PTC_T0CNT_OFF && s_axi_wstrb[0]) begin
			next_cnt0 = s_axi_wdata[7:0];
		end else if (tick0) begin
			if (pwm0) begin
				if (up0 && counter_value == 8'hff) begin
					next_up0  = 1'b0;
					next_cnt0 = counter_value - 8'h01;
				end else if (!up0 && counter_value == 8'h00) begin
					next_up0  = 1'b1;
					next_cnt0 = 8'h01;
				end else begin
					next_cnt0 = up0 ? counter_value + 8'h01 : counter_value - 8'h01;
				end
			end else if (cfg0.mode[0] && counter_value == cmpa0) begin
				next_cnt0 = 8'h00;
			end else begin
				next_cnt0 = counter_value + 8'h01;
			end
		end
	end

	always_comb begin
		next_cnt1 = counter1_value;
		next_up1  = up1;
		if (wr_en && waddr == `PTC_T1CNT_OFF) begin
			next_cnt1 = merge16(counter1_value, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
		end else if (tick1) begin
			if (pwm1) begin
				if (up1 && counter1_value >= top1) begin
					next_up1  = 1'b0;
					next_cnt1 = top1 - 16'h0001;
				end else if (!up1 && counter1_value == 16'h0000) begin
					next_up1  = 1'b1;
					next_cnt1 = 16'h0001;
				end else begin
					next_cnt1 = up1 ? counter1_value + 16'h0001 : counter1_value - 16'h0001;
				end
			end else if (cfg1.mode == ptc_pkg::PTC_T1_CTC && hit[2]) begin
				next_cnt1 = 16'h0000;
			end else begin
				next_cnt1 = counter1_value + 16'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_value  <= 8'h00;
			up0            <= 1'b1;
			counter1_value <= 16'h0000;
			up1            <= 1'b1;
		end else if (ce) begin
			counter_value  <= next_cnt0;
			up0            <= pwm0 ? next_up0 : 1'b1;
			counter1_value <= next_cnt1 & mask1;
			up1            <= pwm1 ? next_up1 : 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bufa0 <= 8'h00;
			bufb0 <= 8'h00;
			cmpa0 <= 8'h00;
			cmpb0 <= 8'h00;
			bufa1 <= 16'h0000;
			bufb1 <= 16'h0000;
			counter1_compare_value <= 16'h0000;
			cmpb1 <= 16'h0000;
			top_buf1 <= `PTC_T1TOP_RST;
			top_act1 <= `PTC_T1TOP_RST;
		end else if (ce) begin
			if (wr_en && waddr == `PTC_T0CMP_OFF) begin
				bufa0 <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : bufa0;
				bufb0 <= s_axi_wstrb[1] ? s_axi_wdata[15:8] : bufb0;
			end
			if (wr_en && waddr == `PTC_T1CMPA_OFF) begin
				bufa1 <= merge16(bufa1, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
			end
			if (wr_en && waddr == `PTC_T1CMPB_OFF) begin
				bufb1 <= merge16(bufb1, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
			end
			if (wr_en && waddr == `PTC_T1TOP_OFF) begin
				top_buf1 <= merge16(top_buf1, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
			end
			if (!pwm0 || at_top0) begin
				cmpa0 <= bufa0;
				cmpb0 <= bufb0;
			end
			if (!pwm1 || at_top1) begin
				counter1_compare_value <= bufa1 & mask1;
				cmpb1 <= bufb1 & mask1;
			end
			// Frequency correct mode moves its top only at bottom to keep periods symmetric
			if (!pwm1 || (cfg1.mode == ptc_pkg::PTC_T1_PWMPFC ? at_bot1 : at_top1)) begin
				top_act1 <= top_buf1;
			end
		end
	end

	// Flags after last match tick, set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= 6'h00;
		end else if (ce) begin
			flags <= ((wr_en && waddr == `PTC_FLAGS_OFF && s_axi_wstrb[0]) ?
				(flags & ~s_axi_wdata[5:0]) : flags) | {ovf1, ovf0, hit};
		end
	end

	// Pin moves on the match tick
	// Pins start low and hold while disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin <= 4'h0;
		end else if (ce) begin
			if (hit[0] && cfg0.com_a_en) pin[0] <= pin_next(pwm0, up0, pin[0]);
			if (hit[1] && cfg0.com_b_en) pin[1] <= pin_next(pwm0, up0, pin[1]);
			if (hit[2] && cfg1.com_a_en) pin[2] <= pin_next(pwm1, up1, pin[2]);
			if (hit[3] && cfg1.com_b_en) pin[3] <= pin_next(pwm1, up1, pin[3]);
		end
	end
	assign compare_output_pin    = pin;
	assign compare_output_pin_oe = {cfg1.com_b_en, cfg1.com_a_en, cfg0.com_b_en, cfg0.com_a_en};

	// Reads return active compares, not the pending buffers
	always_comb begin
		next_rresp = `PTC_RESP_OKAY;
		if (s_axi_araddr == `PTC_CTRL_OFF) begin
			next_rdata = {25'h0, sel1, 1'b0, sel0};
		end else if (s_axi_araddr == `PTC_T0CFG_OFF) begin
			next_rdata = {28'h0, cfg0};
		end else if (s_axi_araddr == `PTC_T0CNT_OFF) begin
			next_rdata = {24'h0, counter_value};
		end else if (s_axi_araddr == `PTC_T0CMP_OFF) begin
			next_rdata = {16'h0, cmpb0, cmpa0};
		end else if (s_axi_araddr == `PTC_T1CFG_OFF) begin
			next_rdata = {27'h0, cfg1};
		end else if (s_axi_araddr == `PTC_T1CNT_OFF) begin
			next_rdata = {16'h0, counter1_value};
		end else if (s_axi_araddr == `PTC_T1CMPA_OFF) begin
			next_rdata = {16'h0, counter1_compare_value};
		end else if (s_axi_araddr == `PTC_T1CMPB_OFF) begin
			next_rdata = {16'h0, cmpb1};
		end else if (s_axi_araddr == `PTC_T1TOP_OFF) begin
			next_rdata = {16'h0, top_act1};
		end else if (s_axi_araddr == `PTC_FLAGS_OFF) begin
			next_rdata = {26'h0, flags};
		end else begin
			next_rdata = 32'h0000_0000;
			next_rresp = `PTC_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `PTC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rresp;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // ptc_timer
`default_nettype wire

// file: verilog/ptc_regs.svh
// Register offsets, field positions, reset values and prescaler taps of the timer pair
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
`define PTC_CTRL_OFF    32'h0000_0000
`define PTC_T0CFG_OFF   32'h0000_0004
`define PTC_T0CNT_OFF   32'h0000_0008
`define PTC_T0CMP_OFF   32'h0000_000c
`define PTC_T1CFG_OFF   32'h0000_0010
`define PTC_T1CNT_OFF   32'h0000_0014
`define PTC_T1CMPA_OFF  32'h0000_0018
`define PTC_T1CMPB_OFF  32'h0000_001c
`define PTC_T1TOP_OFF   32'h0000_0020
`define PTC_FLAGS_OFF   32'h0000_0024
`define PTC_CTRL_SEL0_LSB   0
`define PTC_CTRL_SEL1_LSB   4
`define PTC_CTRL_PSCRST_BIT 8
`define PTC_FLAG_T0A_BIT    0
`define PTC_FLAG_T0B_BIT    1
`define PTC_FLAG_T1A_BIT    2
`define PTC_FLAG_T1B_BIT    3
`define PTC_FLAG_T0OVF_BIT  4
`define PTC_FLAG_T1OVF_BIT  5
`define PTC_TOP8_VAL    16'h00ff
`define PTC_TOP9_VAL    16'h01ff
`define PTC_TOP10_VAL   16'h03ff
`define PTC_FULL_MASK   16'hffff
`define PTC_T1TOP_RST   16'hffff
`define PTC_TAP8        10'h007
`define PTC_TAP64       10'h03f
`define PTC_TAP256      10'h0ff
`define PTC_TAP1024     10'h3ff
`define PTC_RESP_OKAY   2'b00
`define PTC_RESP_SLVERR 2'b10
`endif

// file: verilog/ptc_pkg.sv
// Types shared by the timer pair
package ptc_pkg;
	typedef enum logic [2:0] {
		PTC_T1_NORMAL = 3'h0,
		PTC_T1_CTC    = 3'h1,
		PTC_T1_PWM8   = 3'h2,
		PTC_T1_PWM9   = 3'h3,
		PTC_T1_PWM10  = 3'h4,
		PTC_T1_PWMVAR = 3'h5,
		PTC_T1_PWMPFC = 3'h6,
		PTC_T1_SPARE  = 3'h7
	} ptc_t1mode_type;
	typedef struct packed {
		logic           com_b_en;
		logic           com_a_en;
		ptc_t1mode_type mode;
	} ptc_t1cfg_type;
	typedef struct packed {
		logic       com_b_en;
		logic       com_a_en;
		logic [1:0] mode;
	} ptc_t0cfg_type;
endpackage

// file: tb/ptc_timer_asserts.sv
// Checker for the timer pair bus handshake and compare pins
`timescale 1ns/10ps
`default_nettype none
module ptc_timer_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [3:0]  compare_output_pin,
	input wire logic [3:0]  compare_output_pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take; ce && s_axi_awvalid && s_axi_wvalid && s_axi_awready; endsequence
	sequence s_rd_take; ce && s_axi_arvalid && s_axi_arready; endsequence
	property p_wr_answer; s_wr_take |=> s_axi_bvalid && s_axi_bresp inside {2'b00, 2'b10}; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	property p_r_done; s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid; endproperty
	a_r_done: assert property (p_r_done) else $error("read answered twice");
	// Both halves taken together, never over a pending response
	property p_w_pair; s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid; endproperty
	a_w_pair: assert property (p_w_pair) else $error("write halves split");
	property p_pin_hold;
		1'b1 |=> ((compare_output_pin ^ $past(compare_output_pin)) & ~$past(compare_output_pin_oe)) == 4'h0;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("disabled pin moved");
	property p_pin_reset; $rose(aresetn) |-> compare_output_pin == 4'h0 && compare_output_pin_oe == 4'h0; endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin not zero after reset");
	// Enables come only from a register write
	property p_oe_cause; $changed(compare_output_pin_oe) |-> $past(s_axi_awready); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("enable changed without write");
	// Low enable freezes pins and answers
	property p_ce_freeze;
		!ce |=> $stable(compare_output_pin) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
endmodule // ptc_timer_asserts
bind ptc_timer ptc_timer_asserts u_asserts (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe));
`default_nettype wire

// file: tb/ptc_timer_tb.sv
// Self-checking testbench of the timer pair
`timescale 1ns/10ps
`default_nettype none
`include "ptc_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module ptc_timer_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [3:0]  pin, oe;
	int          error_cnt = 0, cmp_count = 0, cyc = 0;
	ptc_timer u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.compare_output_pin(pin), .compare_output_pin_oe(oe));
	always #25 aclk = ~aclk;
	// Long enough for every scenario with margin, short enough to cut a hang
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask
	task automatic rdr(input logic [31:0] a, input logic [1:0] er = 2'b00);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		`CHK("rresp", er, rresp)
	endtask
	task automatic wtog(input int i, output int t);
		logic v;
		v = pin[i];
		do @(negedge aclk); while (pin[i] === v);
		t = cyc;
	endtask
	task automatic t_reset;
		`CHK("pins", 4'h0, pin)
		`CHK("oe", 4'h0, oe)
		rdr(`PTC_T1TOP_OFF);
		`CHK("top reset", `PTC_T1TOP_RST, rd[15:0])
		rdr(32'h40, `PTC_RESP_SLVERR);
		`CHK("unmapped", 32'h0, rd)
		wr(32'h40, 32'h1, `PTC_RESP_SLVERR);
		$display("reset test done");
	endtask
	// Stopped clock during setup so only the prescaler phase can differ
	task automatic t_ctc(input int c, input int extra, output int d);
		int tb, ta1, ta2, t0;
		logic [3:0] mk;
		mk = c ? 4'hc : 4'h3;
		wr(`PTC_CTRL_OFF, 32'h0);
		wr(c ? `PTC_T1CFG_OFF : `PTC_T0CFG_OFF, c ? 32'h19 : 32'h0d);
		if (c) begin
			wr(`PTC_T1CMPA_OFF, 32'h2);
			wr(`PTC_T1CMPB_OFF, 32'h1);
		end else wr(`PTC_T0CMP_OFF, 32'h0102);
		wr(c ? `PTC_T1CNT_OFF : `PTC_T0CNT_OFF, 32'h0);
		repeat (extra) @(posedge aclk);
		wr(`PTC_CTRL_OFF, 32'h122);
		@(negedge aclk);
		t0 = cyc;
		wtog(2 * c + 1, tb);
		wtog(2 * c, ta1);
		wtog(2 * c, ta2);
		`CHK("b to a", 8, ta1 - tb)
		`CHK("ctc period", 24, ta2 - ta1)
		d = ta1 - t0;
		rdr(`PTC_FLAGS_OFF);
		`CHK("flags", mk, rd[3:0] & mk)
		$display("ctc test done");
	endtask
	task automatic t_hold;
		logic p;
		p = pin[2];
		wr(`PTC_T1CFG_OFF, 32'h11);
		`CHK("oe off", 1'b0, oe[2])
		repeat (60) begin
			@(negedge aclk);
			`CHK("held pin", p, pin[2])
		end
		$display("hold test done");
	endtask
	task automatic t_pwm;
		logic [15:0] m;
		wr(`PTC_CTRL_OFF, 32'h10);
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? `PTC_TOP8_VAL : (i == 1) ? `PTC_TOP9_VAL : `PTC_TOP10_VAL;
			wr(`PTC_T1CFG_OFF, 32'h8 | (i + 2));
			wr(`PTC_T1CNT_OFF, 32'h0);
			wr(`PTC_T1CMPA_OFF, 32'hffff);
			rdr(`PTC_T1CMPA_OFF);
			if (i == 0) `CHK("cmp buffered", 16'h2, rd[15:0])
			wr(`PTC_T1CNT_OFF, 32'hffff);
			rdr(`PTC_T1CNT_OFF);
			`CHK("cnt high bits", 16'h0, rd[15:0] & ~m)
			wr(`PTC_T1CNT_OFF, 32'h0);
			repeat (m + 40) @(posedge aclk);
			rdr(`PTC_T1CMPA_OFF);
			`CHK("cmp masked", m, rd[15:0])
		end
		$display("pwm test done");
	endtask
	task automatic t_var;
		logic [15:0] mx;
		wr(`PTC_T1CFG_OFF, 32'h0);
		wr(`PTC_T1TOP_OFF, 32'h20);
		for (int md = 5; md < 7; md++) begin
			mx = 16'h0;
			wr(`PTC_T1CFG_OFF, md);
			wr(`PTC_T1CNT_OFF, 32'h0);
			repeat (8) begin
				repeat (13) @(posedge aclk);
				rdr(`PTC_T1CNT_OFF);
				`CHK("var top", 1'b1, rd[15:0] <= 16'h20)
				if (rd[15:0] > mx) mx = rd[15:0];
			end
			`CHK("var range", 1'b1, mx > 16'h8)
		end
		$display("variable top test done");
	endtask
	// Twenty frozen edges leave four counting edges between the two reads
	task automatic t_freeze;
		logic [15:0] v;
		wr(`PTC_T1CFG_OFF, 32'h0);
		rdr(`PTC_T1CNT_OFF);
		v = rd[15:0];
		@(posedge aclk);
		ce <= 1'b0;
		repeat (20) @(posedge aclk);
		ce <= 1'b1;
		rdr(`PTC_T1CNT_OFF);
		`CHK("frozen count", 16'h0004, rd[15:0] - v)
		$display("freeze test done");
	endtask
	initial begin
		int d1, d2, dz;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ctc(0, 0, dz);
		t_ctc(1, 0, d1);
		t_ctc(1, 3, d2);
		`CHK("restart", d1, d2)
		t_hold;
		t_pwm;
		t_var;
		t_freeze;
		complete_run;
	end
endmodule // ptc_timer_tb
`default_nettype wire
